// ==== design/rcde_pkg.sv ====
package rcde_pkg;

   // ----------------------------------------------------------------
   // Register indexes; the byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_CTL_A = 6'h1B;
   localparam logic [5:0] IDX_CTL_B = 6'h1C;
   localparam logic [5:0] IDX_CTL_C = 6'h1D;
   localparam logic [5:0] IDX_PATH = 6'h1E;
   localparam logic [5:0] IDX_DRV = 6'h1F;
   localparam logic [5:0] IDX_TAP_HI = 6'h20;
   localparam logic [5:0] IDX_TAP_LO = 6'h21;
   localparam logic [5:0] IDX_MON = 6'h22;
   localparam logic [5:0] IDX_MEAS = 6'h23;
   localparam logic [5:0] IDX_ADAPT = 6'h24;
   localparam logic [5:0] IDX_INT_STS = 6'h30;
   localparam logic [5:0] IDX_INT_MSK = 6'h31;

   // ----------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_CTL_A = 8'h03;
   localparam logic [7:0] RST_CTL_B = 8'h24;
   localparam logic [7:0] RST_CTL_C = 8'h00;
   localparam logic [7:0] RST_PATH = 8'hE1;
   localparam logic [7:0] RST_DRV = 8'h55;
   localparam logic [7:0] RST_TAP = 8'h00;
   localparam logic [7:0] RST_MON = 8'h00;
   localparam logic [7:0] RST_MEAS = 8'h40;

   // ----------------------------------------------------------------
   // Field positions and codes.
   // ----------------------------------------------------------------
   localparam int B_SER_EN = 4;
   localparam int B_DFE_OFF = 3;
   localparam int B_TOP = 7;
   localparam int B_DFE_OVR = 6;
   localparam int B_ERR_LOCK = 6;
   localparam int B_ERR_HITS = 5;
   localparam int B_ERR_VERT = 4;
   localparam int B_RSV3 = 3;
   localparam int B_GO_ADAPT = 2;
   localparam int B_GO_EYE = 1;
   localparam int B_GO_EOM = 0;
   localparam logic [2:0] SEL_RAW = 3'h0;
   localparam logic [2:0] SEL_RETIMED = 3'h1;
   localparam logic [2:0] SEL_PRBS = 3'h4;
   localparam logic [2:0] SEL_MUTE = 3'h7;
   localparam int EV_ADAPT_DONE = 0;
   localparam int EV_EYE_DONE = 1;
   localparam int EV_ADAPT_ERR = 2;
   localparam int EV_EYE_ERR = 3;

   typedef enum logic {ENG_IDLE, ENG_BUSY} rcde_eng_e;

   typedef struct packed {
      logic adapt_done;
      logic adapt_locked;
      logic eye_done;
      logic eye_no_hits;
      logic eye_no_vert;
   } rcde_stat_s;

   typedef struct packed {
      logic [2:0] path_sel;
      logic prbs_ser_en;
      logic dfe_off;
      logic drv_invert;
      logic [15:0] tap_weights;
      logic mon_ovr;
      logic meas_ovr;
      logic dfe_ovr;
      logic [5:0] eye_threshold_level;
      logic fast_eom;
      logic adapt_go;
      logic eye_go;
      logic eom_go;
   } rcde_ctrl_s;

   typedef struct packed {
      logic [7:0] ctl_a;
      logic [7:0] ctl_b;
      logic [7:0] ctl_c;
      logic [7:0] path;
      logic [7:0] drv;
      logic [7:0] tap_hi;
      logic [7:0] tap_lo;
      logic [7:0] mon;
      logic [7:0] meas;
      logic fast_mode;
      logic rsv3;
      logic go_adapt;
      logic go_eye;
      logic go_eom;
      logic err_lock;
      logic err_hits;
      logic err_vert;
      rcde_eng_e a_st;
      rcde_eng_e e_st;
      logic adapt_go;
      logic eye_go;
      logic eom_go;
      logic [3:0] int_sts;
      logic [3:0] int_msk;
      logic [31:0] prdata;
      logic tx_data;
   } rcde_state_s;

endpackage

// ==== design/rcde_bank.sv ====
`timescale 1ns/10ps
`default_nettype none
module rcde_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic manual_tap_en,
   input wire logic raw_data,
   input wire logic retimed_data,
   input wire logic prbs_data,
   input wire rcde_pkg::rcde_stat_s stat,
   output rcde_pkg::rcde_ctrl_s ctrl,
   output logic tx_data,
   output logic irq
);
   import rcde_pkg::*;

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   function automatic logic rcde_mapped(input logic [7:0] a);
      logic [5:0] i;
      i = a[7:2];
      rcde_mapped = (a[1:0] == 2'h0) &&
         (((i >= IDX_CTL_A) && (i <= IDX_ADAPT)) ||
          (i == IDX_INT_STS) || (i == IDX_INT_MSK));
   endfunction

   function automatic logic [7:0] rcde_rd(input rcde_state_s s,
                                          input logic [7:0] a);
      logic [5:0] i;
      i = a[7:2];
      rcde_rd = 8'h00;
      if (i == IDX_CTL_A) begin
         rcde_rd = s.ctl_a;
      end else if (i == IDX_CTL_B) begin
         rcde_rd = s.ctl_b;
      end else if (i == IDX_CTL_C) begin
         rcde_rd = s.ctl_c;
      end else if (i == IDX_PATH) begin
         rcde_rd = s.path;
      end else if (i == IDX_DRV) begin
         rcde_rd = s.drv;
      end else if (i == IDX_TAP_HI) begin
         rcde_rd = s.tap_hi;
      end else if (i == IDX_TAP_LO) begin
         rcde_rd = s.tap_lo;
      end else if (i == IDX_MON) begin
         rcde_rd = s.mon;
      end else if (i == IDX_MEAS) begin
         rcde_rd = s.meas;
      end else if (i == IDX_ADAPT) begin
         rcde_rd = {s.fast_mode, s.err_lock, s.err_hits, s.err_vert,
                    s.rsv3, s.go_adapt, s.go_eye, s.go_eom};
      end else if (i == IDX_INT_STS) begin
         rcde_rd = {4'h0, s.int_sts};
      end else if (i == IDX_INT_MSK) begin
         rcde_rd = {4'h0, s.int_msk};
      end
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   rcde_state_s r_r;
   rcde_state_s r_nxt;
   logic wr;
   logic [5:0] widx;
   logic [3:0] ev;
   logic [2:0] sel;

   assign wr = psel & penable & pwrite;
   assign widx = paddr[7:2];
   assign sel = r_r.path[7:5];

   always_comb begin
      r_nxt = r_r;
      r_nxt.adapt_go = 1'b0;
      r_nxt.eye_go = 1'b0;
      r_nxt.eom_go = 1'b0;
      ev = 4'h0;
      // A start waits in its bit while the engine is busy.
      if (r_r.go_adapt && (r_r.a_st == ENG_IDLE)) begin
         r_nxt.go_adapt = 1'b0;
         r_nxt.adapt_go = 1'b1;
         r_nxt.a_st = ENG_BUSY;
         r_nxt.err_lock = 1'b0;
      end
      if (r_r.go_eye && (r_r.e_st == ENG_IDLE)) begin
         r_nxt.go_eye = 1'b0;
         r_nxt.eye_go = 1'b1;
         r_nxt.e_st = ENG_BUSY;
         r_nxt.err_hits = 1'b0;
         r_nxt.err_vert = 1'b0;
      end
      if (r_r.go_eom) begin
         r_nxt.go_eom = 1'b0;
         r_nxt.eom_go = 1'b1;
      end
      if ((r_r.a_st == ENG_BUSY) && stat.adapt_done) begin
         r_nxt.a_st = ENG_IDLE;
         r_nxt.err_lock = ~stat.adapt_locked;
         ev[EV_ADAPT_DONE] = 1'b1;
         ev[EV_ADAPT_ERR] = ~stat.adapt_locked;
      end
      if ((r_r.e_st == ENG_BUSY) && stat.eye_done) begin
         r_nxt.e_st = ENG_IDLE;
         r_nxt.err_hits = stat.eye_no_hits;
         r_nxt.err_vert = stat.eye_no_vert;
         ev[EV_EYE_DONE] = 1'b1;
         ev[EV_EYE_ERR] = stat.eye_no_hits | stat.eye_no_vert;
      end
      if (wr && rcde_mapped(paddr)) begin
         if (widx == IDX_CTL_A) begin
            r_nxt.ctl_a = pwdata[7:0];
         end else if (widx == IDX_CTL_B) begin
            r_nxt.ctl_b = pwdata[7:0];
         end else if (widx == IDX_CTL_C) begin
            r_nxt.ctl_c = pwdata[7:0];
         end else if (widx == IDX_PATH) begin
            r_nxt.path = pwdata[7:0];
         end else if (widx == IDX_DRV) begin
            r_nxt.drv = pwdata[7:0];
         end else if (widx == IDX_TAP_HI) begin
            r_nxt.tap_hi = pwdata[7:0];
         end else if (widx == IDX_TAP_LO) begin
            r_nxt.tap_lo = pwdata[7:0];
         end else if (widx == IDX_MON) begin
            r_nxt.mon = pwdata[7:0];
         end else if (widx == IDX_MEAS) begin
            r_nxt.meas = pwdata[7:0];
         end else if (widx == IDX_ADAPT) begin
            r_nxt.fast_mode = pwdata[B_TOP];
            r_nxt.rsv3 = pwdata[B_RSV3];
            // Writing zero never cancels a start already pending.
            r_nxt.go_adapt = r_nxt.go_adapt | pwdata[B_GO_ADAPT];
            r_nxt.go_eye = r_nxt.go_eye | pwdata[B_GO_EYE];
            r_nxt.go_eom = r_nxt.go_eom | pwdata[B_GO_EOM];
         end else if (widx == IDX_INT_STS) begin
            r_nxt.int_sts = r_r.int_sts & ~pwdata[3:0];
         end else if (widx == IDX_INT_MSK) begin
            r_nxt.int_msk = pwdata[3:0];
         end
      end
      // New events are ORed in last so they win over a clear.
      r_nxt.int_sts = r_nxt.int_sts | ev;
      if (psel && !penable) begin
         r_nxt.prdata = {24'h0, rcde_rd(r_r, paddr)};
      end
      case (sel)
         SEL_RAW: r_nxt.tx_data = raw_data ^ r_r.drv[B_TOP];
         SEL_RETIMED: r_nxt.tx_data = retimed_data ^ r_r.drv[B_TOP];
         SEL_PRBS: r_nxt.tx_data = (prbs_data & r_r.path[B_SER_EN]) ^
                                   r_r.drv[B_TOP];
         default: r_nxt.tx_data = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r <= '{ctl_a: RST_CTL_A, ctl_b: RST_CTL_B, ctl_c: RST_CTL_C,
                  path: RST_PATH, drv: RST_DRV, tap_hi: RST_TAP,
                  tap_lo: RST_TAP, mon: RST_MON, meas: RST_MEAS,
                  a_st: ENG_IDLE, e_st: ENG_IDLE, default: '0};
      end else begin
         r_r <= r_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = r_r.prdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~rcde_mapped(paddr);
   assign tx_data = r_r.tx_data;
   assign irq = |(r_r.int_sts & r_r.int_msk);

   always_comb begin
      ctrl.path_sel = sel;
      ctrl.prbs_ser_en = r_r.path[B_SER_EN];
      ctrl.dfe_off = r_r.path[B_DFE_OFF];
      ctrl.drv_invert = r_r.drv[B_TOP];
      // Weights are forced to zero while manual_tap_en is low so a stale table cannot leak out.
      ctrl.tap_weights = manual_tap_en ?
                         {r_r.tap_hi, r_r.tap_lo} : 16'h0000;
      ctrl.mon_ovr = r_r.mon[B_TOP];
      ctrl.meas_ovr = r_r.meas[B_TOP];
      ctrl.dfe_ovr = r_r.meas[B_DFE_OVR];
      ctrl.eye_threshold_level = r_r.meas[5:0];
      ctrl.fast_eom = r_r.fast_mode;
      ctrl.adapt_go = r_r.adapt_go;
      ctrl.eye_go = r_r.eye_go;
      ctrl.eom_go = r_r.eom_go;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_adapt_req;
      r_r.go_adapt && (r_r.a_st == ENG_IDLE);
   endsequence
   sequence s_adapt_ack;
      ctrl.adapt_go && !r_r.go_adapt && (r_r.a_st == ENG_BUSY);
   endsequence
   sequence s_eye_req;
      r_r.go_eye && (r_r.e_st == ENG_IDLE);
   endsequence
   sequence s_eye_ack;
      ctrl.eye_go && !r_r.go_eye && (r_r.e_st == ENG_BUSY);
   endsequence

   a_path_mute: assert property ((sel == SEL_MUTE) |=> !tx_data)
      else $error("Muted path drives data.");
   a_path_raw: assert property ((sel == SEL_RAW) |=>
      (tx_data == ($past(raw_data) ^ $past(ctrl.drv_invert))))
      else $error("Raw path data wrong.");
   a_prbs_gate: assert property ((sel == SEL_PRBS) && !ctrl.prbs_ser_en
      |=> tx_data == $past(ctrl.drv_invert))
      else $error("Pattern passes with serializer off.");
   a_dfe_write: assert property (wr && (paddr == {IDX_PATH, 2'h0}) |=>
      ctrl.dfe_off == $past(pwdata[B_DFE_OFF]))
      else $error("Equalizer disable not taken.");
   a_tap_gate: assert property (!manual_tap_en |->
      ctrl.tap_weights == 16'h0000)
      else $error("Weights leak without manual enable.");
   a_tap_order: assert property (manual_tap_en |->
      ctrl.tap_weights[15:12] == r_r.tap_hi[7:4])
      else $error("Tap 5 weight misplaced.");
   a_mon_ovr: assert property (wr && (paddr == {IDX_MON, 2'h0}) |=>
      ctrl.mon_ovr == $past(pwdata[B_TOP]))
      else $error("Monitor override not taken.");
   a_fast_mode: assert property (wr && (paddr == {IDX_ADAPT, 2'h0}) |=>
      ctrl.fast_eom == $past(pwdata[B_TOP]))
      else $error("Fast mode not taken.");
   a_adapt_go: assert property (s_adapt_req |=> s_adapt_ack)
      else $error("Adaptation start not launched.");
   a_eye_go: assert property (s_eye_req |=> s_eye_ack)
      else $error("Eye measurement not launched.");
   a_no_lock: assert property ((r_r.a_st == ENG_BUSY) && stat.adapt_done
      && !stat.adapt_locked |=> r_r.err_lock)
      else $error("No-lock flag missing.");
   a_no_hits: assert property ((r_r.e_st == ENG_BUSY) && stat.eye_done
      && stat.eye_no_hits |=> r_r.err_hits)
      else $error("No-hits flag missing.");
   a_no_vert: assert property ((r_r.e_st == ENG_BUSY) && stat.eye_done
      && stat.eye_no_vert |=> r_r.err_vert)
      else $error("Vertical eye flag missing.");
   a_flag_hold: assert property (r_r.err_lock && !r_r.go_adapt
      |=> r_r.err_lock)
      else $error("No-lock flag lost before restart.");

endmodule
`default_nettype wire

// ==== sim/retimer_channel_dfe_eye_ctrl_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module retimer_channel_dfe_eye_ctrl_tb_top;
   import rcde_pkg::*;
   logic pclk = 1'h0;
   logic presetn, psel, penable, pwrite, manual_tap_en;
   logic raw_data, retimed_data, prbs_data, pready, pslverr, tx_data, irq;
   logic [7:0] paddr;
   logic [7:0] rd;
   logic [31:0] pwdata, prdata;
   logic err_seen;
   rcde_stat_s stat;
   rcde_ctrl_s ctrl;
   int errors = 0;
   int checked = 0;

   rcde_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .manual_tap_en(manual_tap_en), .raw_data(raw_data),
      .retimed_data(retimed_data), .prbs_data(prbs_data), .stat(stat),
      .ctrl(ctrl), .tx_data(tx_data), .irq(irq));

   always #2 pclk = ~pclk;

   // ----------------------------------------------------------------
   // Bus and checking helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // The short pause at the end lets the access edge's updates land.
   task automatic apb(input logic w, input logic [5:0] idx,
                      input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata[7:0];
      err_seen = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      #1;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      apb(1'h1, idx, d);
   endtask

   task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
      apb(1'h0, idx, 8'h00);
      check({24'h0, rd}, {24'h0, exp});
   endtask

   task automatic done_pulse(input logic [4:0] s);
      @(posedge pclk);
      stat <= rcde_stat_s'(s);
      @(posedge pclk);
      stat <= rcde_stat_s'(5'h00);
      @(posedge pclk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [5:0] ix [12];
      logic [7:0] ev [12];
      ix = '{IDX_CTL_A, IDX_CTL_B, IDX_CTL_C, IDX_PATH, IDX_DRV, IDX_TAP_HI,
             IDX_TAP_LO, IDX_MON, IDX_MEAS, IDX_ADAPT, IDX_INT_STS,
             IDX_INT_MSK};
      ev = '{8'h03, 8'h24, 8'h00, 8'hE1, 8'h55, 8'h00, 8'h00, 8'h00, 8'h40,
             8'h00, 8'h00, 8'h00};
      check(32'(ctrl.path_sel), 32'h7);
      check(32'(ctrl.drv_invert), 32'h0);
      for (int i = 0; i < 12; i++) begin
         rdc(ix[i], ev[i]);
      end
      wr(IDX_CTL_A, 8'h5A);
      rdc(IDX_CTL_A, 8'h5A);
      wr(6'h3F, 8'hFF);
      check(32'(err_seen), 32'h1);
      rdc(6'h3F, 8'h00);
   endtask

   task automatic t_path();
      logic [2:0] codes [4];
      logic [2:0] c;
      logic d;
      codes = '{SEL_RAW, SEL_RETIMED, SEL_PRBS, SEL_MUTE};
      for (int inv = 0; inv < 2; inv++) begin
         wr(IDX_DRV, {inv[0], 7'h55});
         check(32'(ctrl.drv_invert), 32'(inv));
         for (int k = 0; k < 4; k++) begin
            c = codes[k];
            wr(IDX_PATH, {c, 1'h1, c[0], 3'h1});
            check(32'(ctrl.path_sel), 32'(c));
            check(32'(ctrl.prbs_ser_en), 32'h1);
            check(32'(ctrl.dfe_off), 32'(c[0]));
            for (int p = 0; p < 2; p++) begin
               @(posedge pclk);
               {raw_data, retimed_data, prbs_data} <= p[0] ? 3'h5 : 3'h2;
               repeat (2) @(posedge pclk);
               #1;
               d = (c == SEL_MUTE) ? 1'h0 :
                   (p[0] ^ (c == SEL_RETIMED) ^ inv[0]);
               check(32'(tx_data), 32'(d));
            end
         end
         // Pattern code with the serializer off sends a constant level equal to the driver invert bit.
         wr(IDX_PATH, {SEL_PRBS, 1'h0, 1'h0, 3'h1});
         check(32'(ctrl.prbs_ser_en), 32'h0);
         @(posedge pclk);
         prbs_data <= 1'h1;
         repeat (2) @(posedge pclk);
         #1;
         check(32'(tx_data), 32'(inv[0]));
      end
   endtask

   task automatic t_taps();
      wr(IDX_TAP_HI, 8'hA5);
      wr(IDX_TAP_LO, 8'h3C);
      @(posedge pclk);
      manual_tap_en <= 1'h0;
      @(posedge pclk);
      #1;
      check(32'(ctrl.tap_weights), 32'h0);
      @(posedge pclk);
      manual_tap_en <= 1'h1;
      @(posedge pclk);
      #1;
      check(32'(ctrl.tap_weights), 32'hA53C);
      wr(IDX_MON, 8'h80);
      check(32'(ctrl.mon_ovr), 32'h1);
      wr(IDX_MEAS, 8'hAB);
      check(32'(ctrl.meas_ovr), 32'h1);
      check(32'(ctrl.dfe_ovr), 32'h0);
      check(32'(ctrl.eye_threshold_level), 32'h2B);
   endtask

   // Interrupt mask first admits only the no-lock event, then only the eye-done event.
   task automatic t_adapt();
      wr(IDX_INT_MSK, 8'h04);
      wr(IDX_ADAPT, 8'h04);
      @(posedge pclk);
      #1;
      check(32'(ctrl.adapt_go), 32'h1);
      @(posedge pclk);
      #1;
      check(32'(ctrl.adapt_go), 32'h0);
      rdc(IDX_ADAPT, 8'h00);
      done_pulse(5'h10);
      rdc(IDX_ADAPT, 8'h40);
      rdc(IDX_INT_STS, 8'h05);
      check(32'(irq), 32'h1);
      wr(IDX_INT_MSK, 8'h02);
      @(posedge pclk);
      #1;
      check(32'(irq), 32'h0);
      wr(IDX_INT_STS, 8'h05);
      rdc(IDX_INT_STS, 8'h00);
   endtask

   task automatic t_eye();
      wr(IDX_ADAPT, 8'h82);
      @(posedge pclk);
      #1;
      check(32'(ctrl.eye_go), 32'h1);
      check(32'(ctrl.fast_eom), 32'h1);
      rdc(IDX_ADAPT, 8'hC0);
      done_pulse(5'h06);
      rdc(IDX_ADAPT, 8'hE0);
      wr(IDX_ADAPT, 8'h82);
      repeat (2) @(posedge pclk);
      done_pulse(5'h05);
      rdc(IDX_ADAPT, 8'hD0);
      wr(IDX_ADAPT, 8'h00);
      rdc(IDX_ADAPT, 8'h50);
      rdc(IDX_INT_STS, 8'h0A);
      wr(IDX_ADAPT, 8'h05);
      @(posedge pclk);
      #1;
      check(32'(ctrl.eom_go), 32'h1);
      check(32'(ctrl.adapt_go), 32'h1);
      done_pulse(5'h18);
      rdc(IDX_ADAPT, 8'h10);
   endtask

   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      manual_tap_en = 1'h0;
      raw_data = 1'h0;
      retimed_data = 1'h0;
      prbs_data = 1'h0;
      stat = rcde_stat_s'(5'h00);
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      t_reset();
      t_path();
      t_taps();
      t_adapt();
      t_eye();
      end_sim();
   end

   initial begin
      #20000;
      errors++;
      end_sim();
   end
endmodule
`default_nettype wire
